// *** rtl/wdbc_defs.vh ***
// Constants for the watchdog boot configuration decoder
`ifndef WDBC_DEFS_VH
`define WDBC_DEFS_VH
`define WDBC_REG_CFG_WORD 12'h000
`define WDBC_REG_CTRL 12'h004
`define WDBC_REG_STATUS 12'h008
`define WDBC_WINSZ_MSB 25
`define WDBC_WINSZ_LSB 24
`define WDBC_FEN_BIT 23
`define WDBC_WDT_WINDOW_DISABLE_BIT 22
`define WDBC_PS_MSB 20
`define WDBC_PS_LSB 16
`define WDBC_PS_MAX 5'h14
`define WDBC_CTRL_ON_BIT 0
`define WDBC_SYNC_STAGES 2'h2
`define WDBC_CFG_RESET 32'hFFFFFFFF
`endif

// *** rtl/wdbc_top.v ***
// Watchdog boot configuration decoder with APB register access
// Function
// - Window size code 11,10,01,00 gives 25%, 37.5%, 50%, 75% window.
// - Forced enable bit 23 keeps watchdog running; otherwise software enables it.
// - Window disable bit 22 set means non-window mode, clear means window mode.
// - Postscale code at bits 20-16 divides by two to the code power.
// - Postscale codes above 10100 act as code 10100.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "wdbc_defs.vh"
module wdbc_top (
    input wire i_mclk,
    input wire i_nrst,
    input wire [31:0] i_cfg_word,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire o_pready,
    output reg [31:0] o_prdata,
    output wire o_pslverr,
    output reg o_wdt_enable,
    output reg o_wdt_window_mode,
    output reg [1:0] o_wdt_window_size_cfg,
    output reg [4:0] o_wdt_postscale_select,
    output reg [20:0] o_wdt_postscale_ratio_m1
);
    localparam RATIO_BITS = 21;

    // Strap synchroniser stages
    reg [31:0] sync1_q;
    reg [31:0] sync2_q;

    // Capture sequencing
    reg [1:0] cap_wait_q;
    reg [1:0] cap_wait_d;
    reg captured_q;
    reg captured_d;
    reg [31:0] cfg_q;
    reg [31:0] cfg_d;
    wire cap_now;

    // Software enable
    reg sw_on_q;
    reg sw_on_d;

    // Field decode
    wire [1:0] win_size;
    wire fen;
    wire win_dis;
    wire [4:0] ps_raw;
    wire ps_over;
    wire [4:0] ps_eff;
    wire [RATIO_BITS-1:0] ratio_m1;

    // Next values of the decoded outputs
    reg wdt_enable_d;
    reg wdt_window_mode_d;
    reg [1:0] wdt_window_size_d;
    reg [4:0] wdt_postscale_select_d;
    reg [RATIO_BITS-1:0] wdt_ratio_m1_d;

    // Bus decode
    wire acc;
    wire setup_rd;
    wire hit_cfg;
    wire hit_ctrl;
    wire hit_status;
    wire known;
    wire wr_ctrl;
    reg [31:0] rd_mux;

    genvar k;

    // Strap synchroniser
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_q <= `WDBC_CFG_RESET;
            sync2_q <= `WDBC_CFG_RESET;
        end else begin
            sync1_q <= i_cfg_word;
            sync2_q <= sync1_q;
        end
    end

    // Count the strap word through the synchroniser
    always @* begin
        cap_wait_d = cap_wait_q;
        if (cap_wait_q != `WDBC_SYNC_STAGES) begin
            cap_wait_d = cap_wait_q + 2'h1;
        end
    end

    assign cap_now = (cap_wait_q == `WDBC_SYNC_STAGES) & ~captured_q;

    // Take the word once, hold it until the next reset
    always @* begin
        captured_d = captured_q;
        cfg_d = cfg_q;
        if (cap_now) begin
            captured_d = 1'b1;
            cfg_d = sync2_q;
        end
    end

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            cap_wait_q <= 2'h0;
            captured_q <= 1'b0;
            cfg_q <= `WDBC_CFG_RESET;
        end else begin
            cap_wait_q <= cap_wait_d;
            captured_q <= captured_d;
            cfg_q <= cfg_d;
        end
    end

    // Field extraction
    assign win_size = cfg_q[`WDBC_WINSZ_MSB:`WDBC_WINSZ_LSB];
    assign fen = cfg_q[`WDBC_FEN_BIT];
    assign win_dis = cfg_q[`WDBC_WDT_WINDOW_DISABLE_BIT];
    assign ps_raw = cfg_q[`WDBC_PS_MSB:`WDBC_PS_LSB];
    assign ps_over = (ps_raw > `WDBC_PS_MAX);
    assign ps_eff = ps_over ? `WDBC_PS_MAX : ps_raw;

    // Divide ratio minus one, one bit per power of two
    generate
        for (k = 0; k < RATIO_BITS; k = k + 1) begin : g_ratio
            assign ratio_m1[k] = ({27'h0, ps_eff} > k);
        end
    endgenerate

    // Bus decode
    assign acc = i_psel & i_penable;
    assign setup_rd = i_psel & ~i_penable & ~i_pwrite;
    assign hit_cfg = (i_paddr == `WDBC_REG_CFG_WORD);
    assign hit_ctrl = (i_paddr == `WDBC_REG_CTRL);
    assign hit_status = (i_paddr == `WDBC_REG_STATUS);
    assign known = hit_cfg | hit_ctrl | hit_status;
    assign wr_ctrl = acc & i_pwrite & hit_ctrl;
    assign o_pready = 1'b1;
    assign o_pslverr = acc & ~known;

    // Software enable, starts off
    always @* begin
        sw_on_d = sw_on_q;
        if (wr_ctrl) begin
            sw_on_d = i_pwdata[`WDBC_CTRL_ON_BIT];
        end
    end

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sw_on_q <= 1'b0;
        end else begin
            sw_on_q <= sw_on_d;
        end
    end

    // Next values, held at zero until the word is captured
    always @* begin
        wdt_enable_d = o_wdt_enable;
        wdt_window_mode_d = o_wdt_window_mode;
        wdt_window_size_d = o_wdt_window_size_cfg;
        wdt_postscale_select_d = o_wdt_postscale_select;
        wdt_ratio_m1_d = o_wdt_postscale_ratio_m1;
        if (captured_q) begin
            wdt_enable_d = fen | sw_on_q;
            wdt_window_mode_d = ~win_dis;
            wdt_window_size_d = win_size;
            wdt_postscale_select_d = ps_eff;
            wdt_ratio_m1_d = ratio_m1;
        end
    end

    // Decoded outputs
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wdt_enable <= 1'b0;
            o_wdt_window_mode <= 1'b0;
            o_wdt_window_size_cfg <= 2'h0;
            o_wdt_postscale_select <= 5'h00;
            o_wdt_postscale_ratio_m1 <= 21'h0;
        end else begin
            o_wdt_enable <= wdt_enable_d;
            o_wdt_window_mode <= wdt_window_mode_d;
            o_wdt_window_size_cfg <= wdt_window_size_d;
            o_wdt_postscale_select <= wdt_postscale_select_d;
            o_wdt_postscale_ratio_m1 <= wdt_ratio_m1_d;
        end
    end

    // Read multiplexer
    always @* begin
        rd_mux = 32'h00000000;
        case (i_paddr)
            `WDBC_REG_CFG_WORD: begin
                rd_mux = cfg_q;
            end
            `WDBC_REG_CTRL: begin
                rd_mux = {31'h0, sw_on_q};
            end
            `WDBC_REG_STATUS: begin
                rd_mux = {24'h000000, o_wdt_postscale_select, o_wdt_window_size_cfg,
                    o_wdt_enable};
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // Read data, loaded in the setup cycle
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_prdata <= 32'h00000000;
        end else if (setup_rd) begin
            o_prdata <= rd_mux;
        end
    end
endmodule

// *** sim/wdbc_sva.sv ***
// Checker for the configuration decoder
`timescale 1ns/1ps
module wdbc_sva (input wire i_mclk, i_nrst, o_wdt_enable, o_wdt_window_mode,
    input wire [31:0] i_cfg_word, input wire [1:0] o_wdt_window_size_cfg,
    input wire [4:0] o_wdt_postscale_select, input wire [20:0] o_wdt_postscale_ratio_m1);
    wire [4:0] ps = i_cfg_word[20:16], sl = o_wdt_postscale_select;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    reg [2:0] age_q;
    reg fen_q;
    always @(posedge i_mclk or negedge i_nrst)
        if (!i_nrst) age_q <= 3'h0;
        else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    always @(posedge i_mclk) if (age_q == 3'h0) fen_q <= i_cfg_word[23];
    sequence u; $rose(i_nrst) ##4 1; endsequence
    property p_r1; u |-> o_wdt_window_size_cfg == i_cfg_word[25:24]; endproperty
    a_r1: assert property (p_r1) else $error("size");
    property p_r2; u |-> (o_wdt_enable == i_cfg_word[23])[*4]; endproperty
    a_r2: assert property (p_r2) else $error("enable");
    property p_r3; u |-> o_wdt_window_mode == !i_cfg_word[22]; endproperty
    a_r3: assert property (p_r3) else $error("mode");
    property p_r4; o_wdt_postscale_ratio_m1 == (21'h1 << sl) - 21'h1; endproperty
    a_r4: assert property (p_r4) else $error("ratio");
    property p_r5; u |-> sl == (ps > 5'h14 ? 5'h14 : ps); endproperty
    a_r5: assert property (p_r5) else $error("select");
    property p_r7;
        age_q == 3'h7 |-> $stable({o_wdt_window_mode, o_wdt_window_size_cfg, sl});
    endproperty
    a_r7: assert property (p_r7) else $error("moved");
    property p_r2f; age_q == 3'h7 && fen_q |-> o_wdt_enable; endproperty
    a_r2f: assert property (p_r2f) else $error("forced");
    c_f: cover property (u ##0 i_cfg_word[23]);
    c_c: cover property (u ##0 ps > 5'h14);
    c_e: cover property ($rose(o_wdt_enable));
endmodule
bind wdbc_top wdbc_sva u_sva (.*);

// *** sim/wdbc_top_tb_top.sv ***
// Bench for the configuration decoder
`timescale 1ns/1ps
module wdbc_top_tb_top;
    reg i_mclk = 0, i_nrst = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
    reg [11:0] i_paddr = 0;
    reg [31:0] i_cfg_word = 0, i_pwdata = 0, s = 32'h8C0D, c;
    wire o_pready, o_pslverr, o_wdt_enable, o_wdt_window_mode;
    wire [31:0] o_prdata;
    wire [1:0] o_wdt_window_size_cfg;
    wire [4:0] o_wdt_postscale_select;
    wire [20:0] o_wdt_postscale_ratio_m1;
    integer n_fail = 0, tests_run = 0, i, t = 0;
    wdbc_top u_wdbc_top (.*);
    initial forever #10 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (++t > 2000) begin
        n_fail++;
        report_and_stop;
    end
    function [31:0] xs(input [31:0] x); begin
        x = x ^ x << 13;
        x = x ^ x >> 17;
        xs = x ^ x << 5;
    end endfunction
    function [4:0] cl(input [31:0] x);
        cl = x[20:16] > 5'h14 ? 5'h14 : x[20:16];
    endfunction
    function [32:0] st(input [31:0] x, input b);
        st = {25'h0, cl(x), x[25:24], x[23] | b};
    endfunction
    task ap(input w, input [11:0] a, input [31:0] d, input [32:0] e); begin
        @(posedge i_mclk) {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
        @(posedge i_mclk) i_penable <= 1;
        do @(posedge i_mclk); while (o_pready !== 1);
        {i_psel, i_penable} <= 0;
        tests_run += !w;
        if (!w && {o_pslverr, o_prdata} !== e) begin
            n_fail++;
            $display("CHECK FAILED reg %h exp %h seen %h", a, e, {o_pslverr, o_prdata});
        end
    end endtask
    task ck(input [21:0] e); begin
        tests_run++;
        if ({o_wdt_window_mode, o_wdt_postscale_ratio_m1} !== e) begin
            n_fail++;
            $display("CHECK FAILED mode_ratio exp %h seen %h", e,
                {o_wdt_window_mode, o_wdt_postscale_ratio_m1});
        end
    end endtask
    task report_and_stop; begin
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    end endtask
    initial begin
        for (i = 0; i < 8; i++) begin
            s = xs(s);
            c = {6'h3F, i[1:0], i[2], i[0], 1'b1, i[0] ? 5'h1F : i[1] ? 5'h14 : s[4:0], s[15:0]};
            i_cfg_word <= c;
            i_nrst <= 0;
            repeat (5) @(posedge i_mclk);
            i_nrst <= 1;
            repeat (6) @(posedge i_mclk);
            ap(1, 12'h004, s, 0);
            ap(0, 12'h008, 0, st(c, s[0]));
            ap(0, 12'h004, 0, {32'h0, s[0]});
            ap(0, 12'hFFC, 0, {1'b1, 32'h0});
            ck({!c[22], (21'h1 << cl(c)) - 21'h1});
            i_cfg_word <= c ^ 32'h03DF0000;
            ap(1, 12'h004, 0, 0);
            repeat (6) @(posedge i_mclk);
            ap(0, 12'h008, 0, st(c, 1'b0));
            ap(0, 12'h000, 0, {1'b0, c});
        end
        report_and_stop;
    end
endmodule
